// ### src/cmc_ctrl.sv
// Core memory bus slave control: decode, sequencing and data register
`timescale 1ns/10ps
module cmc_ctrl
    import cmc_pkg::*;
#(
    parameter logic [DEV_W-1:0] BANK_SEL = BANK_DEFAULT
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              bus_msyn,
    input  wire logic              cycle_type_line_0,
    input  wire logic              cycle_type_line_1,
    input  wire logic [17:1]       bus_addr,
    input  wire logic              byte_select_line,
    input  wire logic [DATA_W-1:0] bus_data_in,
    input  wire logic              bus_dc_lo,
    output logic      [DATA_W-1:0] bus_data_out,
    output logic                   bus_data_oe_n,
    output logic                   bus_ssyn
);

    localparam int FULL_N = FULL_CYC;
    localparam int HALF_N = HALF_CYC;
    // Sense load sits one cycle into the read phase
    localparam int SENSE_TO_WR = HALF_CYC - 2;
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    cmc_bus_t   pin_w;
    cmc_bus_t   s1_r;
    cmc_bus_t   req;
    logic       dc1_r;
    logic       dc_s;

    cmc_state_t        state_r;
    cmc_state_t        state_nxt;
    cmc_cyc_t          type_r;
    cmc_cyc_t          cyc_w;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] data_r;
    logic [DATA_W-1:0] data_nxt;
    logic [DATA_W-1:0] bdat_r;
    logic [DATA_W-1:0] sense_w;
    logic [CNT_W-1:0]  pcnt_r;
    logic [CNT_W-1:0]  tcnt_r;
    logic [CNT_W-1:0]  ack_at;
    logic              pause_r;
    logic              pause_nxt;
    logic              ssyn_r;
    logic              ssyn_nxt;

    wire logic dev_hit;
    wire logic accept;
    wire logic skip;
    wire logic rd_en;
    wire logic wr_en;
    wire logic sense_ld;
    wire logic phase_end;
    wire logic ack_hit;
    wire logic core_busy;

    // Master settles address and type before strobing, so the strobe
    // passing the same two stages lands no earlier than its qualifiers.
    assign pin_w = '{msyn: bus_msyn,
                     ctl:  {cycle_type_line_1, cycle_type_line_0},
                     addr: {bus_addr, byte_select_line},
                     data: bus_data_in};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_r  <= '0;
            req   <= '0;
            dc1_r <= 1'b0;
            dc_s  <= 1'b0;
        end else begin
            s1_r  <= pin_w;
            req   <= s1_r;
            dc1_r <= bus_dc_lo;
            dc_s  <= dc1_r;
        end
    end

    assign cyc_w   = cmc_cyc_t'(req.ctl);
    assign dev_hit = req.addr[ADDR_W-1:DEV_LSB] == BANK_SEL;
    // ssyn still high means the last cycle has not been released yet
    assign accept  = state_r == st_idle && req.msyn && !ssyn_r
                     && dev_hit && !dc_s;
    assign skip    = pause_r && req.ctl[1]
                     && req.addr[ADDR_W-1:WORD_LSB]
                        == addr_r[ADDR_W-1:WORD_LSB];

    assign rd_en     = state_r == st_read && pcnt_r == '0;
    assign sense_ld  = state_r == st_read && pcnt_r == CNT_W'(1);
    assign wr_en     = state_r == st_write && pcnt_r == '0;
    assign phase_end = pcnt_r == CNT_W'(HALF_CYC - 1);
    assign core_busy = state_r == st_read || state_r == st_write;
    assign ack_at    = type_r[1] ? CNT_W'(WACC_CYC - 1)
                                 : CNT_W'(ACC_CYC - 1);
    assign ack_hit   = state_r != st_idle && tcnt_r == ack_at;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            st_idle:  if (accept) begin
                state_nxt = skip ? st_write : st_read;
            end
            st_read:  if (phase_end) begin
                state_nxt = (type_r == read_pause_cycle)
                            ? st_done : st_write;
            end
            st_write: if (phase_end) begin
                state_nxt = st_done;
            end
            st_done:  if (!req.msyn) begin
                state_nxt = st_idle;
            end
        endcase
        if (dc_s) begin
            state_nxt = st_idle;
        end
    end

    always_comb begin
        data_nxt = data_r;
        if (accept && cyc_w == word_write_cycle) begin
            data_nxt = req.data;
        end else if (accept && skip && cyc_w == byte_write_cycle) begin
            data_nxt = byte_merge(data_r, req.data,
                                  req.addr[BYTE_BIT]);
        end else if (sense_ld) begin
            unique case (type_r)
                read_restore_cycle,
                read_pause_cycle: data_nxt = sense_w;
                byte_write_cycle: data_nxt = byte_merge(sense_w, bdat_r,
                                      addr_r[BYTE_BIT]);
                word_write_cycle: data_nxt = data_r;
            endcase
        end
    end

    // Any other cycle after a pause leaves that word lost; flag drops
    assign pause_nxt = dc_s ? 1'b0
                     : accept ? (cyc_w == read_pause_cycle) : pause_r;
    assign ssyn_nxt  = (ssyn_r || ack_hit) && req.msyn && !dc_s;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= st_idle;
            type_r  <= read_restore_cycle;
            addr_r  <= '0;
            bdat_r  <= '0;
            data_r  <= '0;
            pause_r <= 1'b0;
            ssyn_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            data_r  <= data_nxt;
            pause_r <= pause_nxt;
            ssyn_r  <= ssyn_nxt;
            if (accept) begin
                type_r <= cyc_w;
                addr_r <= req.addr;
                bdat_r <= req.data;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pcnt_r <= '0;
            tcnt_r <= '0;
        end else begin
            pcnt_r <= (accept || phase_end) ? '0
                    : (pcnt_r == CNT_MAX) ? pcnt_r : pcnt_r + 1'b1;
            tcnt_r <= accept ? '0
                    : (tcnt_r == CNT_MAX) ? tcnt_r : tcnt_r + 1'b1;
        end
    end

    cmc_core_array #(
        .WORDS_P (WORDS),
        .WIDTH_P (DATA_W),
        .AW_P    (WADDR_W)
    ) u_array (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .rd_en      (rd_en && !dc_s),
        .wr_en      (wr_en && !dc_s),
        .addr       (addr_r[ADDR_W-DEV_W-1:WORD_LSB]),
        .wr_inhibit (~data_r),
        .sense      (sense_w)
    );

    assign bus_ssyn      = ssyn_r;
    assign bus_data_out  = data_r;
    assign bus_data_oe_n = !(ssyn_r && !type_r[1]);

    foreign_silent_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        state_r == st_idle && !dev_hit |=> !rd_en && !bus_ssyn)
        else $error("unselected request answered");

    read_ack_time_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        $rose(bus_ssyn) && !type_r[1] |-> tcnt_r == CNT_W'(ACC_CYC))
        else $error("read acknowledge off time");

    full_cycle_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        $fell(core_busy) && type_r == read_restore_cycle && !dc_s
        |-> tcnt_r == CNT_W'(FULL_N))
        else $error("read restore cycle length wrong");

    pause_skip_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        accept && skip |=> wr_en && !rd_en ##1 !rd_en)
        else $error("write after pause did a read");

    word_read_first_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        accept && !skip && cyc_w == word_write_cycle
        |=> rd_en ##HALF_N wr_en && data_r == $past(req.data, HALF_N + 1))
        else $error("word write sequence wrong");

    restore_same_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        sense_ld && type_r == read_restore_cycle
        |=> data_r == $past(sense_w) ##SENSE_TO_WR
            wr_en && $stable(addr_r))
        else $error("restore lost data");

    byte_keep_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        sense_ld && type_r == byte_write_cycle && !addr_r[BYTE_BIT]
        |=> data_r[DATA_W-1:BYTE_W] == $past(sense_w[DATA_W-1:BYTE_W])
            && data_r[BYTE_W-1:0] == bdat_r[BYTE_W-1:0])
        else $error("byte merge wrong");

    drive_read_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        !bus_data_oe_n |-> bus_ssyn && !type_r[1])
        else $error("data driven outside read");

    addr_latch_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        accept |=> addr_r == $past(req.addr) && pause_r
                   == ($past(cyc_w) == read_pause_cycle))
        else $error("address or pause not captured");

endmodule : cmc_ctrl

// ### shared/cmc_pkg.sv
// Constants, types and helpers for the core memory bus slave control
// Contract
// - Store 8192 words of 16 bits, one location per word.
// - Full cycle 900 ns; read data presented within 400 ns access time.
// - Acknowledge a request, decode the cycle type, launch its timing sequence.
// - Byte writes act only on the byte chosen by the lowest address line.
// - Read or write is chosen from the two cycle type lines.
// - Drive read data onto the bus; take write data from the bus.
// - Writing a 0 asserts that bit's inhibit drive.
// - Writing a 1 leaves that bit's inhibit drive off.
// - A sensed bit sets its data register bit; silent bits read 0.
// - Every read leaves the addressed word all zeros.
// - Data register holds the word read; read-restore writes it back.
// - Word writes load bus data into the data register first; byte writes merge their bus byte after the read.
// - Respond only when the device address field selects this bank.
// - Latch the 18-bit address at the start of each cycle.
// - Read-pause returns data, skips restore, sets pause; master writes next.
// - A write to the same word after read-pause skips its clearing read.
// - Byte write keeps the other byte in the register and restores it.
package cmc_pkg;

    localparam int WORDS    = 8192;
    localparam int DATA_W   = 16;
    localparam int BYTE_W   = 8;
    localparam int ADDR_W   = 18;
    localparam int WADDR_W  = 13;
    localparam int DEV_LSB  = 14;
    localparam int WORD_LSB = 1;
    localparam int BYTE_BIT = 0;
    localparam int DEV_W    = ADDR_W - DEV_LSB;
    localparam int CNT_W    = 5;

    localparam logic [DEV_W-1:0] BANK_DEFAULT = 4'h0;

    localparam int CLK_NS   = 50;
    localparam int FULL_NS  = 900;
    localparam int ACC_NS   = 400;
    localparam int WACC_NS  = 200;
    // Each half is a minimum duration, so round up
    localparam int HALF_CYC = (FULL_NS / 2 + CLK_NS - 1) / CLK_NS;
    localparam int FULL_CYC = 2 * HALF_CYC;
    // Access figures are maxima, so round down
    localparam int ACC_CYC  = ACC_NS / CLK_NS;
    localparam int WACC_CYC = WACC_NS / CLK_NS;

    typedef enum logic [1:0] {
        read_restore_cycle = 2'h0,
        read_pause_cycle   = 2'h1,
        word_write_cycle   = 2'h2,
        byte_write_cycle   = 2'h3
    } cmc_cyc_t;

    typedef enum logic [1:0] {
        st_idle,
        st_read,
        st_write,
        st_done
    } cmc_state_t;

    typedef struct packed {
        logic              msyn;
        logic [1:0]        ctl;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmc_bus_t;

    function automatic logic [DATA_W-1:0] byte_merge(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic              hi
    );
        byte_merge = hi ? {new_w[DATA_W-1:BYTE_W], old_w[BYTE_W-1:0]}
                        : {old_w[DATA_W-1:BYTE_W], new_w[BYTE_W-1:0]};
    endfunction : byte_merge

endpackage : cmc_pkg

// ### src/cmc_core_array.sv
// Core stack model: destructive read with sense, inhibit-controlled write
`timescale 1ns/10ps
module cmc_core_array
    import cmc_pkg::*;
#(
    parameter int WORDS_P = WORDS,
    parameter int WIDTH_P = DATA_W,
    parameter int AW_P    = WADDR_W
) (
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               rd_en,
    input  wire logic               wr_en,
    input  wire logic [AW_P-1:0]    addr,
    input  wire logic [WIDTH_P-1:0] wr_inhibit,
    output logic      [WIDTH_P-1:0] sense
);

    logic [WIDTH_P-1:0] mem [WORDS_P];
    logic [WIDTH_P-1:0] sense_r;

    // A read switches every core to 0; a write only sets uninhibited cores,
    // so a write onto an uncleared word ORs into it.
    always_ff @(posedge ref_clk) begin
        if (rd_en) begin
            mem[addr] <= '0;
        end else if (wr_en) begin
            mem[addr] <= mem[addr] | ~wr_inhibit;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sense_r <= '0;
        end else if (rd_en) begin
            sense_r <= mem[addr];
        end
    end

    assign sense = sense_r;

    read_clears_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        rd_en |=> mem[$past(addr)] == '0)
        else $error("read left cores set");

endmodule : cmc_core_array

// ### test/cmc_master.sv
// Bus master model facing the core memory slave control
`timescale 1ns/10ps
module cmc_master
    import cmc_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              bus_ssyn,
    input  wire logic [DATA_W-1:0] bus_data_out,
    input  wire logic              bus_data_oe_n,
    output logic                   bus_msyn,
    output logic                   cycle_type_line_0,
    output logic                   cycle_type_line_1,
    output logic      [17:1]       bus_addr,
    output logic                   byte_select_line,
    output logic      [DATA_W-1:0] bus_data_in
);
    initial begin
        bus_msyn          = 1'b0;
        cycle_type_line_0 = 1'b0;
        cycle_type_line_1 = 1'b0;
        bus_addr          = '0;
        byte_select_line  = 1'b0;
        bus_data_in       = 16'h0000;
    end

    // One whole transfer; lat is 0 when the slave never answers
    task automatic xfer(
        input  cmc_cyc_t          cyc,
        input  logic [ADDR_W-1:0] addr,
        input  logic [DATA_W-1:0] wdata,
        output logic [DATA_W-1:0] rdata,
        output logic              oe_n,
        output int                lat,
        output bit                hung
    );
        int n;
        lat   = 0;
        rdata = 16'h0000;
        oe_n  = 1'b1;
        @(posedge ref_clk);
        {cycle_type_line_1, cycle_type_line_0} <= cyc;
        bus_addr         <= addr[17:1];
        byte_select_line <= addr[0];
        bus_data_in      <= wdata;
        // Lines settle through the slave's synchronisers before sync
        repeat (3) @(posedge ref_clk);
        bus_msyn <= 1'b1;
        for (n = 1; n <= 30 && lat == 0; n++) begin
            @(posedge ref_clk);
            if (bus_ssyn === 1'b1) begin
                lat   = n;
                rdata = bus_data_out;
                oe_n  = bus_data_oe_n;
            end
        end
        bus_msyn    <= 1'b0;
        // Released lines must not keep showing the old value
        bus_data_in <= ~wdata;
        hung = 1'b1;
        for (n = 0; n < 10 && hung; n++) begin
            @(posedge ref_clk);
            if (bus_ssyn === 1'b0) begin
                hung = 1'b0;
            end
        end
        // Internal core cycle may still be running after ssyn drops
        repeat (20) @(posedge ref_clk);
    endtask : xfer
endmodule : cmc_master

// ### test/tb.sv
// Self-checking testbench for the core memory bus slave control
`timescale 1ns/10ps
module tb import cmc_pkg::*;;
    logic              ref_clk   = 1'b0;
    logic              rst       = 1'b1;
    logic              bus_dc_lo = 1'b0;
    logic              msyn, ctl0, ctl1, bsel, ssyn, oe_n;
    logic [17:1]       addr;
    logic [DATA_W-1:0] din, dout;
    int                errors      = 0;
    int                checks_done = 0;
    int                lat_wr;

    localparam logic [ADDR_W-1:0] A_LO = 18'h00246;
    localparam logic [ADDR_W-1:0] A_HI = 18'h00247;
    // Two sync stages, the accept edge and the master's sampling edge
    localparam int SYNC_LAT = 4;

    always #25 ref_clk = ~ref_clk;

    cmc_ctrl i_cmc_ctrl (.ref_clk(ref_clk), .rst(rst), .bus_msyn(msyn),
        .cycle_type_line_0(ctl0), .cycle_type_line_1(ctl1),
        .bus_addr(addr), .byte_select_line(bsel), .bus_data_in(din),
        .bus_dc_lo(bus_dc_lo), .bus_data_out(dout),
        .bus_data_oe_n(oe_n), .bus_ssyn(ssyn));

    cmc_master i_cmc_master (.ref_clk(ref_clk), .bus_ssyn(ssyn),
        .bus_data_out(dout), .bus_data_oe_n(oe_n), .bus_msyn(msyn),
        .cycle_type_line_0(ctl0), .cycle_type_line_1(ctl1),
        .bus_addr(addr), .byte_select_line(bsel), .bus_data_in(din));

    task automatic report_and_stop();
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input cmc_cyc_t c, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] q, output logic oe,
                       output int lat);
        bit hung;
        i_cmc_master.xfer(c, a, d, q, oe, lat, hung);
        if (hung) begin
            errors++;
            $display("[FAIL] ssyn release expected 0 seen 1");
            report_and_stop();
        end
    endtask : bus

    // Patterns cover all-ones and all-zeros inhibit cases
    task automatic t_word();
        logic [DATA_W-1:0] pat [4] = '{16'hA5C3, 16'hFFFF, 16'h0000, 16'h5A3C};
        logic [DATA_W-1:0] q;
        logic              oe;
        int                lat;
        foreach (pat[i]) begin
            bus(word_write_cycle, A_LO, pat[i], q, oe, lat_wr);
            chk("write oe_n", 1, oe);
            chk("write ack", WACC_CYC + SYNC_LAT, lat_wr);
            bus(read_restore_cycle, A_LO, ~pat[i], q, oe, lat);
            chk("read data", pat[i], q);
            chk("read oe_n", 0, oe);
            chk("access gap", ACC_CYC - WACC_CYC, lat - lat_wr);
            bus(read_restore_cycle, A_LO, pat[i], q, oe, lat);
            chk("restored data", pat[i], q);
        end
    endtask : t_word

    task automatic t_byte();
        logic [DATA_W-1:0] q;
        logic              oe;
        int                lat;
        bus(byte_write_cycle, A_HI, 16'h7EAA, q, oe, lat);
        chk("byte write ack", lat_wr, lat);
        bus(read_restore_cycle, A_LO, 16'h0000, q, oe, lat);
        chk("high byte write", 16'h7E3C, q);
        bus(byte_write_cycle, A_LO, 16'h9911, q, oe, lat);
        chk("byte write oe_n", 1, oe);
        bus(read_restore_cycle, A_LO, 16'h0000, q, oe, lat);
        chk("low byte write", 16'h7E11, q);
    endtask : t_byte

    // Clearing read after a pause would lose the kept low byte
    task automatic t_pause();
        logic [DATA_W-1:0] q;
        logic              oe;
        int                lat;
        bus(read_pause_cycle, A_LO, 16'h0000, q, oe, lat);
        chk("pause read data", 16'h7E11, q);
        chk("pause access", ACC_CYC - WACC_CYC, lat - lat_wr);
        bus(byte_write_cycle, A_HI, 16'h3C00, q, oe, lat);
        chk("write after pause ack", lat_wr, lat);
        bus(read_restore_cycle, A_LO, 16'h0000, q, oe, lat);
        chk("byte after pause", 16'h3C11, q);
    endtask : t_pause

    task automatic t_refuse();
        logic [DATA_W-1:0] q;
        logic              oe;
        int                lat;
        bus(word_write_cycle, 18'h04246, 16'h0F0F, q, oe, lat);
        chk("foreign bank ack", 0, lat);
        @(posedge ref_clk);
        bus_dc_lo <= 1'b1;
        repeat (3) @(posedge ref_clk);
        bus(word_write_cycle, 18'h00246, 16'h0F0F, q, oe, lat);
        chk("power fail ack", 0, lat);
        bus_dc_lo <= 1'b0;
        repeat (3) @(posedge ref_clk);
        bus(word_write_cycle, 18'h03FFE, 16'h1234, q, oe, lat);
        bus(read_restore_cycle, A_LO, 16'h0000, q, oe, lat);
        chk("word untouched", 16'h3C11, q);
        bus(read_restore_cycle, 18'h03FFE, 16'h0000, q, oe, lat);
        chk("top word", 16'h1234, q);
    endtask : t_refuse

    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_word();
        t_byte();
        t_pause();
        t_refuse();
        report_and_stop();
    end
endmodule : tb
